// file: hw/bdc_diag_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// RL1: bit15 promotes retried masters to top tier
// RL2: bit14 set blocks parity error passing
// RL3: bit13 enables upstream locks, reset off
// RL4: bit12 enables downstream locks, reset on
// RL5: bit11 selects slow secondary decode
// RL6: bit10 selects slow primary decode
// RL7: bits 9:8 always read zero
// RL8: bit7 lets arbiter timeout raise system error
// RL9: bit6 enables transaction ordering, reset on
// RL10: bit5 extends secondary counter 16 to 64
// RL11: bit4 switches off primary data counter
// RL12: secondary data counter never disabled
// RL13: bit3 extends primary counter 16 to 64
// RL14: bit2 clear enables immediate retry
// RL15: bit1 parks secondary bus on bridge
// RL16: register loads 1040h on reset
// RL17: software keeps bit0 zero normally
// RL18: 16-clock grant without start sets sticky flag
// RL19: timeout system error sets own sticky flag
module bdc_diag_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // arbiter events and bridge settings
  input wire bdc_pkg::bdc_arb_ev_t arb_ev,
  output bdc_pkg::bdc_cfg_t cfg,
  // system error request and interrupt
  output logic serr_req,
  output logic irq
);
  import bdc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // turn the control word into the settings the datapath uses
  function automatic bdc_cfg_t bdc_decode(input logic [15:0] c);
    bdc_cfg_t d;
    d.promote_en = c[BDC_B_PROMOTE]; // see RL1
    d.par_pass_block = c[BDC_B_PAR_BLOCK]; // see RL2
    d.us_lock_en = c[BDC_B_US_LOCK]; // see RL3
    d.ds_lock_en = c[BDC_B_DS_LOCK]; // see RL4
    d.sec_slow_dec = c[BDC_B_SEC_SLOW]; // see RL5
    d.pri_slow_dec = c[BDC_B_PRI_SLOW]; // see RL6
    d.serr_on_tmo = c[BDC_B_SERR_TMO]; // see RL8
    d.order_en = c[BDC_B_ORDER]; // see RL9
    d.sec_idp_limit = c[BDC_B_SEC_EXT] ? BDC_IDP_LONG
                                       : BDC_IDP_SHORT; // see RL10
    // no control bit reaches the secondary counter enable
    d.sec_idp_en = 1'b1; // see RL12
    d.pri_idp_en = ~c[BDC_B_PRI_OFF]; // see RL11
    d.pri_idp_limit = c[BDC_B_PRI_EXT] ? BDC_IDP_LONG
                                       : BDC_IDP_SHORT; // see RL13
    d.imm_retry_en = ~c[BDC_B_NO_RETRY]; // see RL14
    d.park_on_bridge = c[BDC_B_PARK]; // see RL15
    return d;
  endfunction

  // read-back value of a register, zero for unmapped addresses
  function automatic logic [31:0] bdc_read(input logic [7:0] a,
                                           input bdc_state_t st);
    logic [31:0] v;
    v = 32'h00000000;
    if (a == BDC_OFS_CTRL) begin
      v = {16'h0000, st.ctrl & ~BDC_CTRL_RSVD}; // see RL7
    end else if (a == BDC_OFS_STS) begin
      v = {30'h00000000, st.sts};
    end else if (a == BDC_OFS_ENA) begin
      v = {30'h00000000, st.ena};
    end
    return v;
  endfunction

  // true for an address that answers OKAY
  function automatic logic bdc_mapped(input logic [7:0] a);
    return (a == BDC_OFS_CTRL) || (a == BDC_OFS_STS) ||
           (a == BDC_OFS_CLR) || (a == BDC_OFS_ENA);
  endfunction

  // ---------------------------------------------------------------
  // state and next state
  // ---------------------------------------------------------------
  bdc_state_t s;
  bdc_state_t next_s;
  logic wr_go;
  logic tmo_evt;
  logic serr_evt;
  logic [1:0] clr;

  // all register, bus and timer behaviour in one place
  always_comb begin
    next_s = s;
    clr = 2'h0;
    tmo_evt = 1'b0;
    serr_evt = 1'b0;
    // address and data are collected separately, in either order
    wr_go = s.aw_got && s.w_got && !s.bvalid;
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata[15:0];
      next_s.wstrb = wstrb[1:0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // commit a write once both halves are held
    if (wr_go) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = bdc_mapped(s.awaddr) ? BDC_RESP_OKAY
                                          : BDC_RESP_SLVERR;
      if (s.awaddr == BDC_OFS_CTRL) begin
        if (s.wstrb[0]) begin
          next_s.ctrl[7:0] = s.wdata[7:0];
        end
        if (s.wstrb[1]) begin
          next_s.ctrl[15:8] = s.wdata[15:8];
        end
        // reserved bits never store, whatever is written
        next_s.ctrl = next_s.ctrl & ~BDC_CTRL_RSVD; // see RL7
      end else if (s.awaddr == BDC_OFS_ENA) begin
        if (s.wstrb[0]) begin
          next_s.ena = s.wdata[1:0];
        end
      end else if (s.awaddr == BDC_OFS_CLR) begin
        clr = s.wdata[1:0] & {2{s.wstrb[0]}};
      end
    end
    // one write in flight; ready drops while held or answering
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    // reads are answered at the edge that takes the address
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = bdc_read(araddr, s);
      next_s.rresp = bdc_mapped(araddr) ? BDC_RESP_OKAY
                                        : BDC_RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;
    // grant-to-start watchdog; a new grant restarts the count
    if (arb_ev.gnt) begin
      next_s.tmo_act = 1'b1;
      next_s.tmo_cnt = 5'h00;
    end else if (s.tmo_act) begin
      if (arb_ev.frame_start) begin
        next_s.tmo_act = 1'b0;
      end else if (s.tmo_cnt == BDC_ARB_TMO - 5'h01) begin
        next_s.tmo_act = 1'b0;
        tmo_evt = 1'b1; // see RL18
      end else begin
        next_s.tmo_cnt = s.tmo_cnt + 5'h01;
      end
    end
    // system error only when software allowed it
    serr_evt = tmo_evt && s.ctrl[BDC_B_SERR_TMO]; // see RL8
    // sticky flags: a set in the clearing cycle survives
    next_s.sts = (s.sts & ~clr) | {serr_evt, tmo_evt}; // see RL19
    next_s.serr = serr_evt;
    next_s.irq = |(next_s.sts & next_s.ena);
    // settings follow the stored word in the same edge
    next_s.cfg = bdc_decode(next_s.ctrl);
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= BDC_STATE_RST; // see RL16
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign cfg = s.cfg;
  assign serr_req = s.serr;
  assign irq = s.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // a control write with both byte lanes is committed
  sequence q_ctrl_wr;
    wr_go && s.awaddr == BDC_OFS_CTRL && s.wstrb == 2'h3;
  endsequence

  property p_rst_val;
    disable iff (1'b0)
    !aresetn |=> s.ctrl == BDC_CTRL_RST && cfg.ds_lock_en && cfg.order_en;
  endproperty
  a_rst_val: assert property (p_rst_val) // see RL16
    else $error("control word not at reset value");

  property p_rsvd_zero;
    rvalid |-> rdata[9:8] == 2'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // see RL7
    else $error("reserved control bits read nonzero");

  property p_promote;
    q_ctrl_wr |=> cfg.promote_en == $past(s.wdata[15]);
  endproperty
  a_promote: assert property (p_promote) // see RL1
    else $error("promotion setting does not follow write");

  property p_sec_limit;
    q_ctrl_wr |=> cfg.sec_idp_limit ==
      ($past(s.wdata[5]) ? BDC_IDP_LONG : BDC_IDP_SHORT);
  endproperty
  a_sec_limit: assert property (p_sec_limit) // see RL10
    else $error("secondary counter limit wrong");

  property p_pri_off;
    q_ctrl_wr |=> cfg.pri_idp_en == !$past(s.wdata[4]);
  endproperty
  a_pri_off: assert property (p_pri_off) // see RL11
    else $error("primary counter enable wrong");

  property p_sec_on;
    cfg.sec_idp_en;
  endproperty
  a_sec_on: assert property (p_sec_on) // see RL12
    else $error("secondary counter disabled");

  property p_retry;
    q_ctrl_wr |=> cfg.imm_retry_en == !$past(s.wdata[2]) &&
      cfg.park_on_bridge == $past(s.wdata[1]);
  endproperty
  a_retry: assert property (p_retry) // see RL14
    else $error("retry or parking setting wrong");

  sequence q_tmo_last;
    s.tmo_act && s.tmo_cnt == BDC_ARB_TMO - 5'h01 &&
      !arb_ev.gnt && !arb_ev.frame_start;
  endsequence

  property p_tmo_flag;
    q_tmo_last |=> s.sts[BDC_S_TMO];
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) // see RL18
    else $error("timeout flag not set after 16 clocks");

  property p_tmo_cause;
    $rose(s.sts[BDC_S_TMO]) |-> $past(s.tmo_act);
  endproperty
  a_tmo_cause: assert property (p_tmo_cause) // see RL18
    else $error("timeout flag set without a pending grant");

  property p_serr;
    q_tmo_last |=> serr_req == $past(s.ctrl[BDC_B_SERR_TMO]) &&
      (serr_req ? s.sts[BDC_S_SERR] : 1'b1);
  endproperty
  a_serr: assert property (p_serr) // see RL19
    else $error("system error request or its flag wrong");

  property p_irq;
    ##1 irq == |($past(next_s.sts) & $past(next_s.ena));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not match enabled flags");

  property p_parity;
    q_ctrl_wr |=> cfg.par_pass_block == $past(s.wdata[BDC_B_PAR_BLOCK]);
  endproperty
  a_parity: assert property (p_parity) // see RL2
    else $error("parity passing setting does not follow write");

  property p_us_lock;
    q_ctrl_wr |=> cfg.us_lock_en == $past(s.wdata[BDC_B_US_LOCK]);
  endproperty
  a_us_lock: assert property (p_us_lock) // see RL3
    else $error("upstream lock setting does not follow write");

  property p_ds_lock;
    q_ctrl_wr |=> cfg.ds_lock_en == $past(s.wdata[BDC_B_DS_LOCK]);
  endproperty
  a_ds_lock: assert property (p_ds_lock) // see RL4
    else $error("downstream lock setting does not follow write");

  property p_sec_dec;
    q_ctrl_wr |=> cfg.sec_slow_dec == $past(s.wdata[BDC_B_SEC_SLOW]);
  endproperty
  a_sec_dec: assert property (p_sec_dec) // see RL5
    else $error("secondary decode speed does not follow write");

  property p_pri_dec;
    q_ctrl_wr |=> cfg.pri_slow_dec == $past(s.wdata[BDC_B_PRI_SLOW]);
  endproperty
  a_pri_dec: assert property (p_pri_dec) // see RL6
    else $error("primary decode speed does not follow write");

  property p_serr_en;
    q_ctrl_wr |=> cfg.serr_on_tmo == $past(s.wdata[BDC_B_SERR_TMO]);
  endproperty
  a_serr_en: assert property (p_serr_en) // see RL8
    else $error("timeout reporting setting does not follow write");

  property p_order;
    q_ctrl_wr |=> cfg.order_en == $past(s.wdata[BDC_B_ORDER]);
  endproperty
  a_order: assert property (p_order) // see RL9
    else $error("ordering setting does not follow write");

  property p_pri_limit;
    q_ctrl_wr |=> cfg.pri_idp_limit ==
      ($past(s.wdata[BDC_B_PRI_EXT]) ? BDC_IDP_LONG : BDC_IDP_SHORT);
  endproperty
  a_pri_limit: assert property (p_pri_limit) // see RL13
    else $error("primary counter limit wrong");

  property p_rsvd_store;
    s.ctrl[9:8] == 2'h0;
  endproperty
  a_rsvd_store: assert property (p_rsvd_store) // see RL7
    else $error("reserved control bits stored nonzero");

  property p_serr_once;
    serr_req |=> !serr_req;
  endproperty
  a_serr_once: assert property (p_serr_once) // see RL8
    else $error("system error request longer than one cycle");

  property p_cancel;
    s.tmo_act && arb_ev.frame_start && !arb_ev.gnt |=>
      !s.tmo_act && !$rose(s.sts[BDC_S_TMO]);
  endproperty
  a_cancel: assert property (p_cancel) // see RL18
    else $error("cycle start did not cancel the watch");

  property p_restart;
    arb_ev.gnt |=> s.tmo_act && s.tmo_cnt == 5'h00;
  endproperty
  a_restart: assert property (p_restart) // see RL18
    else $error("grant did not start the watch afresh");

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before it was taken");

  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped before it was taken");

endmodule

// file: inc/bdc_pkg.sv
package bdc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] BDC_OFS_CTRL = 8'h5C;
  localparam logic [7:0] BDC_OFS_STS = 8'h60;
  localparam logic [7:0] BDC_OFS_CLR = 8'h64;
  localparam logic [7:0] BDC_OFS_ENA = 8'h68;

  // control register reset value and reserved bits
  localparam logic [15:0] BDC_CTRL_RST = 16'h1040;
  localparam logic [15:0] BDC_CTRL_RSVD = 16'h0300;

  // control field positions
  localparam int BDC_B_PROMOTE = 15;
  localparam int BDC_B_PAR_BLOCK = 14;
  localparam int BDC_B_US_LOCK = 13;
  localparam int BDC_B_DS_LOCK = 12;
  localparam int BDC_B_SEC_SLOW = 11;
  localparam int BDC_B_PRI_SLOW = 10;
  localparam int BDC_B_SERR_TMO = 7;
  localparam int BDC_B_ORDER = 6;
  localparam int BDC_B_SEC_EXT = 5;
  localparam int BDC_B_PRI_OFF = 4;
  localparam int BDC_B_PRI_EXT = 3;
  localparam int BDC_B_NO_RETRY = 2;
  localparam int BDC_B_PARK = 1;

  // status / clear / enable field positions
  localparam int BDC_S_TMO = 0;
  localparam int BDC_S_SERR = 1;

  // counts of bus clocks
  localparam logic [6:0] BDC_IDP_SHORT = 7'h10;
  localparam logic [6:0] BDC_IDP_LONG = 7'h40;
  localparam logic [4:0] BDC_ARB_TMO = 5'h10;

  // AXI response codes
  localparam logic [1:0] BDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BDC_RESP_SLVERR = 2'h2;

  // decoded settings handed to the bridge datapath
  typedef struct packed {
    logic promote_en;
    logic par_pass_block;
    logic us_lock_en;
    logic ds_lock_en;
    logic sec_slow_dec;
    logic pri_slow_dec;
    logic serr_on_tmo;
    logic order_en;
    logic [6:0] sec_idp_limit;
    logic sec_idp_en;
    logic pri_idp_en;
    logic [6:0] pri_idp_limit;
    logic imm_retry_en;
    logic park_on_bridge;
  } bdc_cfg_t;

  // arbiter events from the bridge, same clock
  typedef struct packed {
    logic gnt;
    logic frame_start;
  } bdc_arb_ev_t;

  // whole state of the block
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] ctrl;
    logic [1:0] sts;
    logic [1:0] ena;
    logic irq;
    logic serr;
    logic tmo_act;
    logic [4:0] tmo_cnt;
    bdc_cfg_t cfg;
  } bdc_state_t;

  localparam bdc_state_t BDC_STATE_RST = '{
    awready: 1'b1, wready: 1'b1, aw_got: 1'b0, awaddr: 8'h00,
    w_got: 1'b0, wdata: 16'h0000, wstrb: 2'h0, bvalid: 1'b0,
    bresp: 2'h0, arready: 1'b1, rvalid: 1'b0, rresp: 2'h0,
    rdata: 32'h00000000, ctrl: BDC_CTRL_RST, sts: 2'h0, ena: 2'h0,
    irq: 1'b0, serr: 1'b0, tmo_act: 1'b0, tmo_cnt: 5'h00,
    cfg: '{promote_en: 1'b0, par_pass_block: 1'b0, us_lock_en: 1'b0,
      ds_lock_en: 1'b1, sec_slow_dec: 1'b0, pri_slow_dec: 1'b0,
      serr_on_tmo: 1'b0, order_en: 1'b1, sec_idp_limit: BDC_IDP_SHORT,
      sec_idp_en: 1'b1, pri_idp_en: 1'b1, pri_idp_limit: BDC_IDP_SHORT,
      imm_retry_en: 1'b1, park_on_bridge: 1'b0}
  };

endpackage

// file: sim/bridge_diag_control_tb.sv
`timescale 1ns/1ps
module bridge_diag_control_tb;
  import bdc_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  bdc_arb_ev_t arb_ev = '0;
  logic awready, wready, bvalid, arready, rvalid, serr_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  bdc_cfg_t cfg;
  int fail_count = 0;
  int comparisons = 0;

  // 100 MHz bus clock
  always #5 aclk = ~aclk;

  bdc_diag_ctrl DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .arb_ev(arb_ev), .cfg(cfg), .serr_req(serr_req), .irq(irq)
  );

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a wait that ran out ends the run at once
  task automatic hang(input string nm);
    fail_count++;
    $display("[ERR] %s expected handshake seen none", nm);
    end_sim();
  endtask

  // expected settings, worked out bit by bit from the control word
  function automatic bdc_cfg_t exp_cfg(input logic [15:0] v);
    bdc_cfg_t c;
    c.promote_en = v[15];
    c.par_pass_block = v[14];
    c.us_lock_en = v[13];
    c.ds_lock_en = v[12];
    c.sec_slow_dec = v[11];
    c.pri_slow_dec = v[10];
    c.serr_on_tmo = v[7];
    c.order_en = v[6];
    c.sec_idp_limit = v[5] ? 7'h40 : 7'h10;
    c.sec_idp_en = 1'h1;
    c.pri_idp_en = !v[4];
    c.pri_idp_limit = v[3] ? 7'h40 : 7'h10;
    c.imm_retry_en = !v[2];
    c.park_on_bridge = v[1];
    return c;
  endfunction

  // ------------------------------------------------------------
  // register bus master
  // ------------------------------------------------------------
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    bit ok;
    ok = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    repeat (40) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 1'h0;
        ok = 1'h1;
        break;
      end
    end
    if (!ok) hang("bvalid");
    // idle edge keeps drivers from being assigned twice at one edge
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    bit ok;
    ok = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    repeat (40) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        rready <= 1'h0;
        ok = 1'h1;
        break;
      end
    end
    if (!ok) hang("rvalid");
    @(posedge aclk);
  endtask

  // grant pulse, optional frame start; edges counted from the grant
  task automatic arb(input int fs_at, output int k_irq, k_serr, n_serr);
    k_irq = 0;
    k_serr = 0;
    n_serr = 0;
    arb_ev <= '{gnt: 1'h1, frame_start: 1'h0};
    for (int k = 1; k <= 20; k++) begin
      @(posedge aclk);
      arb_ev <= '{gnt: 1'h0, frame_start: 1'(k == fs_at)};
      #1;
      if (serr_req === 1'h1) n_serr++;
      if (serr_req === 1'h1 && k_serr == 0) k_serr = k;
      if (irq === 1'h1 && k_irq == 0) k_irq = k;
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("ready", 32'h7, 32'({awready, wready, arready}));
    rd(BDC_OFS_CTRL, 32'h1040, BDC_RESP_OKAY);
    chk("cfg", 32'(exp_cfg(16'h1040)), 32'(cfg));
    rd(BDC_OFS_STS, 32'h0, BDC_RESP_OKAY);
    rd(BDC_OFS_ENA, 32'h0, BDC_RESP_OKAY);
    $display("test reset done");
  endtask

  // every field flipped both ways; reserved pair must stay zero
  task automatic t_ctrl();
    logic [15:0] v [3] = '{16'hFFFF, 16'h5A5A, 16'h0000};
    foreach (v[i]) begin
      wr(BDC_OFS_CTRL, {16'h0, v[i]}, 4'hF, BDC_RESP_OKAY);
      rd(BDC_OFS_CTRL, {16'h0, v[i] & 16'hFCFF}, BDC_RESP_OKAY);
      chk("cfg", 32'(exp_cfg(v[i])), 32'(cfg));
    end
    // low lane only: upper byte keeps its zeros
    wr(BDC_OFS_CTRL, 32'hFFFF, 4'h1, BDC_RESP_OKAY);
    rd(BDC_OFS_CTRL, 32'h00FF, BDC_RESP_OKAY);
    $display("test control done");
  endtask

  task automatic t_bus();
    wr(8'h10, 32'hFFFF, 4'hF, BDC_RESP_SLVERR);
    rd(8'h10, 32'h0, BDC_RESP_SLVERR);
    rd(BDC_OFS_CTRL, 32'h00FF, BDC_RESP_OKAY);
    wr(BDC_OFS_STS, 32'h3, 4'hF, BDC_RESP_OKAY);
    rd(BDC_OFS_STS, 32'h0, BDC_RESP_OKAY);
    rd(BDC_OFS_CLR, 32'h0, BDC_RESP_OKAY);
    $display("test bus done");
  endtask

  task automatic t_tmo();
    int ki, ks, ns;
    wr(BDC_OFS_ENA, 32'h3, 4'hF, BDC_RESP_OKAY);
    wr(BDC_OFS_CTRL, 32'h10C0, 4'hF, BDC_RESP_OKAY);
    arb(0, ki, ks, ns);
    chk("irq_edge", 32'h11, 32'(ki));
    chk("serr_edge", 32'h11, 32'(ks));
    chk("serr_pulses", 32'h1, 32'(ns));
    rd(BDC_OFS_STS, 32'h3, BDC_RESP_OKAY);
    wr(BDC_OFS_CLR, 32'h1, 4'hF, BDC_RESP_OKAY);
    rd(BDC_OFS_STS, 32'h2, BDC_RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    wr(BDC_OFS_CLR, 32'h2, 4'hF, BDC_RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
    // a cycle start inside the window cancels the watch
    arb(5, ki, ks, ns);
    chk("irq_edge", 32'h0, 32'(ki));
    chk("serr_pulses", 32'h0, 32'(ns));
    // reporting off and flag masked: flag only, no line moves
    wr(BDC_OFS_CTRL, 32'h1040, 4'hF, BDC_RESP_OKAY);
    wr(BDC_OFS_ENA, 32'h2, 4'hF, BDC_RESP_OKAY);
    arb(0, ki, ks, ns);
    chk("serr_pulses", 32'h0, 32'(ns));
    chk("irq_edge", 32'h0, 32'(ki));
    rd(BDC_OFS_STS, 32'h1, BDC_RESP_OKAY);
    $display("test timeout done");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_ctrl();
    t_bus();
    t_tmo();
    // leave a non-default word so the second reset has work to do
    wr(BDC_OFS_CTRL, 32'h2C84, 4'hF, BDC_RESP_OKAY);
    // second reset in mid-run must restore the defaults
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    end_sim();
  end
endmodule
